// ==== shared/ssp_params.svh ====
// Register map, field positions, reset values and widths of the serial port
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ==========================================================
// Register indices on the plain register port
`define SSP_ADDR_W          4
`define SSP_IDX_INTCTL      4'h0
`define SSP_IDX_PIFLAGS     4'h1
`define SSP_IDX_PIENABLES   4'h2
`define SSP_IDX_PIPRIORITY  4'h3
`define SSP_IDX_RXSTATCTL   4'h4
`define SSP_IDX_TXBUF       4'h5
`define SSP_IDX_TXSTATCTL   4'h6
`define SSP_IDX_BAUDDIV     4'h7
`define SSP_IDX_RXBUF       4'h8

// ==========================================================
// Reset values
`define SSP_RST_INTCTL      8'h00
`define SSP_RST_PIFLAGS     8'h00
`define SSP_RST_PIENABLES   8'h00
`define SSP_RST_PIPRIORITY  8'h00
`define SSP_RST_RXSTATCTL   8'h00
`define SSP_RST_TXBUF       8'h00
`define SSP_RST_TXSTATCTL   8'h02
`define SSP_RST_BAUDDIV     8'h00
`define SSP_RST_RXBUF       8'h00

// ==========================================================
// Field positions
`define SSP_B_GIE           7
`define SSP_B_PERIPHERAL_INT_ENABLE          6
`define SSP_B_RX_COMPLETE_FLAG          5
`define SSP_B_TX_BUFFER_EMPTY_FLAG          4
`define SSP_B_SERIAL_PORT_ENABLE          7
`define SSP_B_RX9           6
`define SSP_B_SINGLE_RX_ENABLE          5
`define SSP_B_CONTINUOUS_RX_ENABLE          4
`define SSP_B_ADDEN         3
`define SSP_B_FERR          2
`define SSP_B_OERR          1
`define SSP_B_RX_NINTH_BIT          0
`define SSP_B_CLOCK_SOURCE_SELECT          7
`define SSP_B_TX9           6
`define SSP_B_TX_ENABLE_BIT          5
`define SSP_B_SYNC          4
`define SSP_B_BRGH          2
`define SSP_B_SHIFT_EMPTY_FLAG          1
`define SSP_B_TX_NINTH_BIT          0

// ==========================================================
// Word lengths in bits, minus one for the counters
`define SSP_LAST_BIT_8      4'h7
`define SSP_LAST_BIT_9      4'h8

`endif

// ==== shared/ssp_pkg.sv ====
// Types shared by the serial port design and its bench
`include "ssp_params.svh"
package ssp_pkg;

	typedef logic [7:0] ssp_byte_t;
	typedef logic [`SSP_ADDR_W-1:0] ssp_addr_t;

	typedef enum logic [1:0] {
		SSP_MODE_OFF,
		SSP_MODE_ASYNC,
		SSP_MODE_MASTER,
		SSP_MODE_SLAVE
	} ssp_mode_t;

endpackage : ssp_pkg

// ==== design/ssp_top.sv ====
// Synchronous slave serial port with register file, transmit and receive paths
`timescale 1ns/100ps
`include "ssp_params.svh"

// Behaviour
// - Shift clock comes from the external clock pin in slave mode.
// - Shifting continues while the chip sleeps, clocked from outside.
// - Clearing clock_source_select (transmit control bit 7) selects slave mode.
// - Slave transmit behaves like master transmit, except during sleep.
// - With two words written, first goes to shift register; second waits, flag clear.
// - After first word shifts out, second loads, then empty flag sets.
// - Empty flag with tx_interrupt_enable raises interrupt, which wakes the chip.
// - Wake interrupt branches to vector only with global interrupt enable set.
// - single_rx_enable is ignored in slave reception.
// - continuous_rx_enable set keeps receiving words during sleep.
// - Full word moves into rx_buffer; enabled interrupt wakes the chip.
// - rx_complete_flag sets on completion; interrupt only when enabled.
// - Clearing continuous_rx_enable clears the receive error condition.
// - Empty flag sets regardless of enable; only a write to the transmit buffer clears it.
// - Read-only shift_empty_flag shows an empty shift register, no interrupt.
// - Receive data sampled at falling edge of the shift clock.
module ssp_top (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire ssp_pkg::ssp_addr_t reg_addr,
	input  wire ssp_pkg::ssp_byte_t reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output ssp_pkg::ssp_byte_t     reg_rdata,
	input  wire logic              sleep_active,
	input  wire logic              serial_clock_pin_in,
	output logic                   serial_clock_pin_out,
	output logic                   serial_clock_pin_oe,
	input  wire logic              serial_data_pin_in,
	output logic                   serial_data_pin_out,
	output logic                   serial_data_pin_oe,
	output logic                   wake_req,
	output logic                   vector_req
);
	import ssp_pkg::*;

	// ==========================================================
	// Register storage
	ssp_byte_t intctl_reg;
	ssp_byte_t pienables_reg;
	ssp_byte_t pipriority_reg;
	ssp_byte_t bauddiv_reg;
	ssp_byte_t tx_buffer_reg;
	ssp_byte_t rx_buffer_reg;
	ssp_byte_t rdata_reg;
	logic      serial_port_enable_reg;
	logic      rx9_reg;
	logic      single_rx_enable_reg;
	logic      continuous_rx_enable_reg;
	logic      adden_reg;
	logic      oerr_reg;
	logic      rx_ninth_bit_reg;
	logic      clock_source_select_reg;
	logic      tx9_reg;
	logic      tx_enable_bit_reg;
	logic      sync_reg;
	logic      brgh_reg;
	logic      tx_ninth_bit_reg;

	// ==========================================================
	// Datapath state
	logic       tx_full_reg;
	logic       tx_buffer_empty_flag_reg;
	logic       shift_empty_flag_reg;
	logic [8:0] tsr_reg;
	logic [3:0] tx_cnt_reg;
	logic       rx_complete_flag_reg;
	logic [8:0] rsr_reg;
	logic [3:0] rx_cnt_reg;
	logic       ck_meta_reg;
	logic       ck_sync_reg;
	logic       ck_prev_reg;
	logic       dt_meta_reg;
	logic       dt_sync_reg;

	// ==========================================================
	// Decode and derived controls
	ssp_mode_t mode;
	logic      wr_txbuf;
	logic      rd_rxbuf;
	logic      ck_rise;
	logic      ck_fall;
	logic      slave_on;
	logic      tx_run;
	logic      rx_run;
	logic      tx_load;
	logic      rx_last;
	logic      rx_done;
	logic      rx_accept;
	logic [8:0] rx_word;
	logic [3:0] tx_last_bit;
	logic [3:0] rx_last_bit;
	logic      irq_any;

	always_comb begin
		if (!serial_port_enable_reg) begin
			mode = SSP_MODE_OFF;
		end else if (!sync_reg) begin
			mode = SSP_MODE_ASYNC;
		end else if (clock_source_select_reg) begin
			mode = SSP_MODE_MASTER;
		end else begin
			mode = SSP_MODE_SLAVE;
		end
	end

	always_comb begin
		unique case (mode)
			SSP_MODE_SLAVE:  slave_on = 1'b1;
			SSP_MODE_OFF:    slave_on = 1'b0;
			SSP_MODE_ASYNC:  slave_on = 1'b0;
			SSP_MODE_MASTER: slave_on = 1'b0;
		endcase
	end

	assign wr_txbuf    = reg_wr && (reg_addr == `SSP_IDX_TXBUF);
	assign rd_rxbuf    = reg_rd && (reg_addr == `SSP_IDX_RXBUF);
	assign tx_last_bit = tx9_reg ? `SSP_LAST_BIT_9 : `SSP_LAST_BIT_8;
	assign rx_last_bit = rx9_reg ? `SSP_LAST_BIT_9 : `SSP_LAST_BIT_8;
	// Sleep does not gate shifting; the clock comes from the pin
	assign tx_run      = slave_on && tx_enable_bit_reg;
	assign rx_run      = slave_on && continuous_rx_enable_reg && !oerr_reg;
	assign tx_load     = tx_run && shift_empty_flag_reg && tx_full_reg;

	// ==========================================================
	// Pin synchronisers and clock edge detection
	always_ff @(posedge clk) begin
		if (srst) begin
			ck_meta_reg <= 1'b1;
			ck_sync_reg <= 1'b1;
			ck_prev_reg <= 1'b1;
		end else begin
			ck_meta_reg <= serial_clock_pin_in;
			ck_sync_reg <= ck_meta_reg;
			ck_prev_reg <= ck_sync_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dt_meta_reg <= 1'b0;
			dt_sync_reg <= 1'b0;
		end else begin
			dt_meta_reg <= serial_data_pin_in;
			dt_sync_reg <= dt_meta_reg;
		end
	end

	assign ck_rise = ck_sync_reg && !ck_prev_reg;
	assign ck_fall = !ck_sync_reg && ck_prev_reg;

	// ==========================================================
	// Transmit buffer and empty flag
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_buffer_reg <= `SSP_RST_TXBUF;
			tx_full_reg   <= 1'b0;
		end else begin
			if (wr_txbuf) begin
				tx_buffer_reg <= reg_wdata;
			end
			// A write in the load cycle leaves the new byte waiting
			if (wr_txbuf) begin
				tx_full_reg <= 1'b1;
			end else if (tx_load) begin
				tx_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tx_buffer_empty_flag_reg <= 1'b0;
		end else if (wr_txbuf) begin
			tx_buffer_empty_flag_reg <= 1'b0;
		end else if (tx_load) begin
			tx_buffer_empty_flag_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Transmit shift register, advanced on rising clock edges
	always_ff @(posedge clk) begin
		if (srst) begin
			tsr_reg    <= 9'h000;
			tx_cnt_reg <= 4'h0;
			shift_empty_flag_reg   <= 1'b1;
		end else if (!tx_run) begin
			tx_cnt_reg <= 4'h0;
			shift_empty_flag_reg   <= 1'b1;
		end else if (tx_load) begin
			tsr_reg    <= {tx_ninth_bit_reg, tx_buffer_reg};
			tx_cnt_reg <= 4'h0;
			shift_empty_flag_reg   <= 1'b0;
		end else if (!shift_empty_flag_reg && ck_rise) begin
			if (tx_cnt_reg == tx_last_bit) begin
				shift_empty_flag_reg <= 1'b1;
			end else begin
				tsr_reg    <= {1'b0, tsr_reg[8:1]};
				tx_cnt_reg <= tx_cnt_reg + 4'h1;
			end
		end
	end

	// ==========================================================
	// Receive shift register, sampled on falling clock edges
	always_comb begin
		rx_word = rsr_reg;
		rx_word[rx_cnt_reg] = dt_sync_reg;
	end

	assign rx_last   = rx_cnt_reg == rx_last_bit;
	assign rx_done   = rx_run && ck_fall && rx_last;
	assign rx_accept = rx_done && (!rx_complete_flag_reg || rd_rxbuf);

	always_ff @(posedge clk) begin
		if (srst) begin
			rsr_reg    <= 9'h000;
			rx_cnt_reg <= 4'h0;
		end else if (!rx_run) begin
			rx_cnt_reg <= 4'h0;
		end else if (ck_fall) begin
			rsr_reg <= rx_word;
			if (rx_last) begin
				rx_cnt_reg <= 4'h0;
			end else begin
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_buffer_reg <= `SSP_RST_RXBUF;
			rx_ninth_bit_reg      <= 1'b0;
		end else if (rx_accept) begin
			rx_buffer_reg <= rx_word[7:0];
			rx_ninth_bit_reg      <= rx9_reg ? rx_word[8] : 1'b0;
		end
	end

	// Completion wins over a read in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_complete_flag_reg <= 1'b0;
		end else if (rx_accept) begin
			rx_complete_flag_reg <= 1'b1;
		end else if (rd_rxbuf) begin
			rx_complete_flag_reg <= 1'b0;
		end
	end

	// Overrun: word finished while the previous one is unread
	always_ff @(posedge clk) begin
		if (srst) begin
			oerr_reg <= 1'b0;
		end else if (!continuous_rx_enable_reg) begin
			oerr_reg <= 1'b0;
		end else if (rx_done && !rx_accept) begin
			oerr_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Control register writes
	always_ff @(posedge clk) begin
		if (srst) begin
			intctl_reg     <= `SSP_RST_INTCTL;
			pienables_reg  <= `SSP_RST_PIENABLES;
			pipriority_reg <= `SSP_RST_PIPRIORITY;
			bauddiv_reg    <= `SSP_RST_BAUDDIV;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`SSP_IDX_INTCTL:     intctl_reg     <= reg_wdata;
				`SSP_IDX_PIENABLES:  pienables_reg  <= reg_wdata;
				`SSP_IDX_PIPRIORITY: pipriority_reg <= reg_wdata;
				`SSP_IDX_BAUDDIV:    bauddiv_reg    <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			serial_port_enable_reg  <= 1'(`SSP_RST_RXSTATCTL >> `SSP_B_SERIAL_PORT_ENABLE);
			rx9_reg   <= 1'(`SSP_RST_RXSTATCTL >> `SSP_B_RX9);
			single_rx_enable_reg  <= 1'(`SSP_RST_RXSTATCTL >> `SSP_B_SINGLE_RX_ENABLE);
			continuous_rx_enable_reg  <= 1'(`SSP_RST_RXSTATCTL >> `SSP_B_CONTINUOUS_RX_ENABLE);
			adden_reg <= 1'(`SSP_RST_RXSTATCTL >> `SSP_B_ADDEN);
		end else if (reg_wr && reg_addr == `SSP_IDX_RXSTATCTL) begin
			serial_port_enable_reg  <= reg_wdata[`SSP_B_SERIAL_PORT_ENABLE];
			rx9_reg   <= reg_wdata[`SSP_B_RX9];
			single_rx_enable_reg  <= reg_wdata[`SSP_B_SINGLE_RX_ENABLE];
			continuous_rx_enable_reg  <= reg_wdata[`SSP_B_CONTINUOUS_RX_ENABLE];
			adden_reg <= reg_wdata[`SSP_B_ADDEN];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			clock_source_select_reg <= 1'(`SSP_RST_TXSTATCTL >> `SSP_B_CLOCK_SOURCE_SELECT);
			tx9_reg  <= 1'(`SSP_RST_TXSTATCTL >> `SSP_B_TX9);
			tx_enable_bit_reg <= 1'(`SSP_RST_TXSTATCTL >> `SSP_B_TX_ENABLE_BIT);
			sync_reg <= 1'(`SSP_RST_TXSTATCTL >> `SSP_B_SYNC);
			brgh_reg <= 1'(`SSP_RST_TXSTATCTL >> `SSP_B_BRGH);
			tx_ninth_bit_reg <= 1'(`SSP_RST_TXSTATCTL >> `SSP_B_TX_NINTH_BIT);
		end else if (reg_wr && reg_addr == `SSP_IDX_TXSTATCTL) begin
			clock_source_select_reg <= reg_wdata[`SSP_B_CLOCK_SOURCE_SELECT];
			tx9_reg  <= reg_wdata[`SSP_B_TX9];
			tx_enable_bit_reg <= reg_wdata[`SSP_B_TX_ENABLE_BIT];
			sync_reg <= reg_wdata[`SSP_B_SYNC];
			brgh_reg <= reg_wdata[`SSP_B_BRGH];
			tx_ninth_bit_reg <= reg_wdata[`SSP_B_TX_NINTH_BIT];
		end
	end

	// ==========================================================
	// Register read, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`SSP_IDX_INTCTL:     rdata_reg <= intctl_reg;
				`SSP_IDX_PIFLAGS:    rdata_reg <= {2'b00, rx_complete_flag_reg, tx_buffer_empty_flag_reg, 4'h0};
				`SSP_IDX_PIENABLES:  rdata_reg <= pienables_reg;
				`SSP_IDX_PIPRIORITY: rdata_reg <= pipriority_reg;
				`SSP_IDX_RXSTATCTL:  rdata_reg <= {serial_port_enable_reg, rx9_reg, single_rx_enable_reg, continuous_rx_enable_reg,
					adden_reg, 1'b0, oerr_reg, rx_ninth_bit_reg};
				`SSP_IDX_TXBUF:      rdata_reg <= tx_buffer_reg;
				`SSP_IDX_TXSTATCTL:  rdata_reg <= {clock_source_select_reg, tx9_reg, tx_enable_bit_reg, sync_reg,
					1'b0, brgh_reg, shift_empty_flag_reg, tx_ninth_bit_reg};
				`SSP_IDX_BAUDDIV:    rdata_reg <= bauddiv_reg;
				`SSP_IDX_RXBUF:      rdata_reg <= rx_buffer_reg;
				default:             rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata = rdata_reg;

	// ==========================================================
	// Wake and vector requests
	assign irq_any = (tx_buffer_empty_flag_reg && pienables_reg[`SSP_B_TX_BUFFER_EMPTY_FLAG])
		|| (rx_complete_flag_reg && pienables_reg[`SSP_B_RX_COMPLETE_FLAG]);
	assign wake_req   = irq_any && sleep_active;
	assign vector_req = irq_any && intctl_reg[`SSP_B_GIE] && intctl_reg[`SSP_B_PERIPHERAL_INT_ENABLE];

	// ==========================================================
	// Pins
	assign serial_clock_pin_out = 1'b0;
	assign serial_clock_pin_oe  = 1'b0;
	assign serial_data_pin_out  = tsr_reg[0];
	assign serial_data_pin_oe   = tx_run && !continuous_rx_enable_reg;

endmodule : ssp_top

// ==== test/ssp_top_props.sv ====
// Concurrent checks on the serial port pins and register port
`timescale 1ns/100ps
`include "ssp_params.svh"
module ssp_top_props (
	input wire logic               clk,
	input wire logic               srst,
	input wire ssp_pkg::ssp_addr_t reg_addr,
	input wire ssp_pkg::ssp_byte_t reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire ssp_pkg::ssp_byte_t reg_rdata,
	input wire logic               sleep_active,
	input wire logic               serial_clock_pin_in,
	input wire logic               serial_clock_pin_out,
	input wire logic               serial_clock_pin_oe,
	input wire logic               serial_data_pin_in,
	input wire logic               serial_data_pin_out,
	input wire logic               serial_data_pin_oe,
	input wire logic               wake_req,
	input wire logic               vector_req
);
	import ssp_pkg::*;
	// ==========================================
	// Shadow copies of the control registers
	ssp_byte_t ictl_reg;
	ssp_byte_t pien_reg;
	ssp_byte_t rxc_reg;
	ssp_byte_t txc_reg;
	logic      drive_exp;
	always_ff @(posedge clk) begin
		if (srst) begin
			ictl_reg <= 8'h00;
			pien_reg <= 8'h00;
			rxc_reg  <= 8'h00;
			txc_reg  <= 8'h00;
		end else if (reg_wr) begin
			if (reg_addr == `SSP_IDX_INTCTL) ictl_reg <= reg_wdata;
			if (reg_addr == `SSP_IDX_PIENABLES) pien_reg <= reg_wdata;
			if (reg_addr == `SSP_IDX_RXSTATCTL) rxc_reg <= reg_wdata;
			if (reg_addr == `SSP_IDX_TXSTATCTL) txc_reg <= reg_wdata;
		end
	end
	assign drive_exp = rxc_reg[7] & txc_reg[4] & ~txc_reg[7] & txc_reg[5] & ~rxc_reg[4];
	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	clk_oe_off_a: assert property (!serial_clock_pin_oe)
		else $error("clock pin driven");
	clk_out_low_a: assert property (!serial_clock_pin_out)
		else $error("clock pin output not low");
	data_oe_mode_a: assert property (serial_data_pin_oe == drive_exp)
		else $error("data pin enable wrong for mode");
	wake_sleep_a: assert property (wake_req |-> sleep_active)
		else $error("wake outside sleep");
	wake_enable_a: assert property (wake_req |-> (pien_reg[5] || pien_reg[4]))
		else $error("wake without enable");
	vector_gate_a: assert property (vector_req |-> ictl_reg[7] && ictl_reg[6])
		else $error("vector without global enables");
	vector_wakes_a: assert property (vector_req && sleep_active |-> wake_req)
		else $error("interrupt did not wake");
	wake_vector_a: assert property (wake_req && ictl_reg[7] && ictl_reg[6] |-> vector_req)
		else $error("enabled wake without vector");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	cover property (vector_req);
	cover property (wake_req && !vector_req);
	cover property ($rose(serial_data_pin_oe));
endmodule : ssp_top_props

bind ssp_top ssp_top_props chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sleep_active(sleep_active), .serial_clock_pin_in(serial_clock_pin_in),
	.serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
	.serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
	.serial_data_pin_oe(serial_data_pin_oe), .wake_req(wake_req), .vector_req(vector_req));

// ==== test/ssp_master_model.sv ====
// External synchronous master: makes the shift clock, sends and takes data
`timescale 1ns/100ps
module ssp_master_model #(
	parameter int HALF_NS = 100
) (
	output logic      ck_pin,
	output logic      dt_drv,
	input  wire logic dt_wire
);
	initial begin
		ck_pin = 1'b1;
		dt_drv = 1'b0;
	end
	// Clock idles high; data set while high, taken by device at the fall
	task automatic frame(input logic [8:0] w, input int n, output logic [8:0] got);
		got = 9'h000;
		// Keep pin edges off the system clock edges
		#3;
		for (int i = 0; i < n; i++) begin
			dt_drv = w[i];
			#(HALF_NS) ck_pin = 1'b0;
			#(HALF_NS - 5) got[i] = dt_wire;
			#5 ck_pin = 1'b1;
		end
		#(HALF_NS) dt_drv = ~dt_drv;
	endtask : frame
endmodule : ssp_master_model

// ==== test/test_sync_serial_slave_port.sv ====
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/100ps
`include "ssp_params.svh"
module test_sync_serial_slave_port;
	import ssp_pkg::*;
	logic       clk, srst, reg_wr, reg_rd, sleep_active, wake_req, vector_req;
	logic       ck_pin, ck_out, ck_oe, ck_wire, dt_drv, dt_out, dt_oe, dt_wire;
	ssp_addr_t  reg_addr;
	ssp_byte_t  reg_wdata, reg_rdata;
	logic [8:0] got;
	int         mismatches, checks_done;
	assign ck_wire = ck_oe ? ck_out : ck_pin;
	assign dt_wire = dt_oe ? dt_out : dt_drv;
	ssp_top uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_active(sleep_active),
		.serial_clock_pin_in(ck_wire), .serial_clock_pin_out(ck_out),
		.serial_clock_pin_oe(ck_oe), .serial_data_pin_in(dt_wire),
		.serial_data_pin_out(dt_out), .serial_data_pin_oe(dt_oe),
		.wake_req(wake_req), .vector_req(vector_req));
	ssp_master_model mst (.ck_pin(ck_pin), .dt_drv(dt_drv), .dt_wire(dt_wire));
	// ==========================================
	// Shared tasks
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input ssp_addr_t a, input ssp_byte_t v);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input ssp_addr_t a, input ssp_byte_t m, input ssp_byte_t e, input string s);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk((reg_rdata & m) === e, s);
	endtask : rdc
	// ==========================================
	// Scenarios
	task automatic t_reset;
		ssp_byte_t ev [0:8] = '{`SSP_RST_INTCTL, `SSP_RST_PIFLAGS, `SSP_RST_PIENABLES,
			`SSP_RST_PIPRIORITY, `SSP_RST_RXSTATCTL, `SSP_RST_TXBUF, `SSP_RST_TXSTATCTL,
			`SSP_RST_BAUDDIV, `SSP_RST_RXBUF};
		for (int i = 0; i < 9; i++) rdc(ssp_addr_t'(i), 8'hff, ev[i], "reset value");
		rdc(4'hf, 8'hff, 8'h00, "unmapped read");
	endtask : t_reset
	task automatic t_tx;
		wr(`SSP_IDX_RXSTATCTL, 8'h80);
		wr(`SSP_IDX_TXSTATCTL, 8'h10);
		wr(`SSP_IDX_PIENABLES, 8'h10);
		wr(`SSP_IDX_TXSTATCTL, 8'h30);
		wr(`SSP_IDX_TXBUF, 8'ha5);
		wr(`SSP_IDX_TXBUF, 8'h3c);
		sleep_active <= 1'b1;
		rdc(`SSP_IDX_PIFLAGS, 8'h10, 8'h00, "empty flag early");
		rdc(`SSP_IDX_TXSTATCTL, 8'h02, 8'h00, "shift reg idle");
		chk(wake_req === 1'b0, "early wake");
		mst.frame(9'h000, 8, got);
		chk(got[7:0] === 8'ha5, "first word");
		@(negedge clk);
		chk(wake_req === 1'b1 && vector_req === 1'b0, "wake after load");
		rdc(`SSP_IDX_PIFLAGS, 8'h10, 8'h10, "flag after load");
		wr(`SSP_IDX_PIFLAGS, 8'h00);
		rdc(`SSP_IDX_PIFLAGS, 8'h10, 8'h10, "flag cleared by write");
		wr(`SSP_IDX_INTCTL, 8'hc0);
		@(negedge clk);
		chk(vector_req === 1'b1, "no vector");
		mst.frame(9'h000, 8, got);
		chk(got[7:0] === 8'h3c, "second word");
		rdc(`SSP_IDX_TXSTATCTL, 8'h02, 8'h02, "shift reg not empty");
	endtask : t_tx
	task automatic t_tx9;
		wr(`SSP_IDX_TXSTATCTL, 8'h71);
		wr(`SSP_IDX_TXBUF, 8'h5a);
		mst.frame(9'h000, 9, got);
		chk(got === 9'h15a, "nine-bit word");
	endtask : t_tx9
	task automatic t_rx;
		wr(`SSP_IDX_TXSTATCTL, 8'h10);
		wr(`SSP_IDX_PIENABLES, 8'h00);
		wr(`SSP_IDX_RXSTATCTL, 8'hb0);
		mst.frame(9'h096, 8, got);
		@(negedge clk);
		chk(wake_req === 1'b0, "wake with rx int off");
		rdc(`SSP_IDX_PIFLAGS, 8'h20, 8'h20, "rx flag");
		mst.frame(9'h03c, 8, got);
		rdc(`SSP_IDX_RXSTATCTL, 8'h02, 8'h02, "no overrun");
		wr(`SSP_IDX_RXSTATCTL, 8'h80);
		rdc(`SSP_IDX_RXSTATCTL, 8'h02, 8'h00, "overrun kept");
		rdc(`SSP_IDX_RXBUF, 8'hff, 8'h96, "first rx word");
		wr(`SSP_IDX_RXSTATCTL, 8'h90);
		wr(`SSP_IDX_PIENABLES, 8'h20);
		mst.frame(9'h069, 8, got);
		@(negedge clk);
		chk(wake_req === 1'b1 && vector_req === 1'b1, "no rx wake");
		rdc(`SSP_IDX_RXBUF, 8'hff, 8'h69, "sleep rx word");
		chk(wake_req === 1'b0, "flag kept after read");
		wr(`SSP_IDX_RXSTATCTL, 8'hd0);
		mst.frame(9'h1a5, 9, got);
		@(posedge clk);
		sleep_active <= 1'b0;
		@(negedge clk);
		chk(wake_req === 1'b0 && vector_req === 1'b1, "wake while awake");
		rdc(`SSP_IDX_RXSTATCTL, 8'h01, 8'h01, "ninth rx bit");
		rdc(`SSP_IDX_RXBUF, 8'hff, 8'ha5, "nine-bit rx word");
	endtask : t_rx
	task automatic final_report;
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	// ==========================================
	// Clock, reset, sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		srst         = 1'b1;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		reg_addr     = 4'h0;
		reg_wdata    = 8'h00;
		sleep_active = 1'b0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_tx();
		t_tx9();
		t_rx();
		final_report();
	end
	// Whole run needs about 15 us
	initial begin
		#200000;
		mismatches++;
		final_report();
	end
endmodule : test_sync_serial_slave_port
